// ### rtl/ebm_pkg.sv
// package: register map, field positions and reset values of the bus mux
package ebm_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] CSA_OFFSET       = 12'h11c;
    localparam logic [31:0] CSA_RESET        = 32'h00010000;
    localparam int          CS1_SDRAM_BIT    = 1;
    localparam int          CS3_NAND_BIT     = 3;
    localparam int          CS4_CARD0_BIT    = 4;
    localparam int          CS5_CARD1_BIT    = 5;
    localparam int          PULLUP_DIS_BIT   = 8;
    localparam int          VOLT_SEL_BIT     = 16;
    localparam int          SLEW_SEL_BIT     = 17;
    localparam logic [31:0] CSA_WRITE_MASK   = 32'h0003013a;
    // ************************************************************
    // pin widths
    // ************************************************************
    localparam int          ADDR_W           = 26;
    localparam int          DATA_W           = 32;
    localparam int          NUM_CS           = 8;
    localparam int          SDR_ADDR_W       = 13;
    localparam int          NUM_SPACES       = 6;
    typedef enum logic [1:0] {
        EBM_OWN_STATIC,
        EBM_OWN_SDRAM,
        EBM_OWN_IDLE
    } ebm_owner_t;
endpackage

// ### rtl/ebm_ctrl_if.sv
// interface: configuration bits passed from register file to pin mux
`timescale 1ns/10ps
interface ebm_ctrl_if;
    logic       sdramOnSelect1;
    logic       nandLogicOnSelect3;
    logic       cardSlot0OnSelect4;
    logic       cardSlot1OnSelect5;
    logic       dataPullupDisable;
    logic       memoryVoltageSelect;
    logic       padSlewSelect;
    modport regs (output sdramOnSelect1, nandLogicOnSelect3,
                  cardSlot0OnSelect4, cardSlot1OnSelect5,
                  dataPullupDisable, memoryVoltageSelect, padSlewSelect);
    modport mux  (input sdramOnSelect1, nandLogicOnSelect3,
                  cardSlot0OnSelect4, cardSlot1OnSelect5,
                  dataPullupDisable, memoryVoltageSelect, padSlewSelect);
endinterface

// ### rtl/ebm_apb_regs.sv
// apb slave holding the chip-select assignment register
`timescale 1ns/10ps
module ebm_apb_regs
    import ebm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    ebm_ctrl_if.regs         ctrl
);
    logic [31:0] csa_q;
    logic [31:0] csa_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        hit;
    logic [31:0] laneMask;

    assign hit     = (paddr[11:2] == CSA_OFFSET[11:2]);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = rdata_q;

    // data is latched in setup so read data is a flip-flop at the access
    always_comb begin
        laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
        csa_d    = csa_q;
        rdata_d  = rdata_q;
        if (psel && penable && pwrite && hit) begin
            // reserved bits stay zero whatever is written
            csa_d = (csa_q & ~(laneMask & CSA_WRITE_MASK))
                  | (pwdata & laneMask & CSA_WRITE_MASK); // RULE15
        end
        if (psel && !penable) begin
            rdata_d = hit ? csa_q : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            csa_q   <= CSA_RESET; // RULE7
            rdata_q <= 32'h00000000;
        end else begin
            csa_q   <= csa_d;
            rdata_q <= rdata_d;
        end
    end

    assign ctrl.sdramOnSelect1      = csa_q[CS1_SDRAM_BIT];
    assign ctrl.nandLogicOnSelect3  = csa_q[CS3_NAND_BIT];
    assign ctrl.cardSlot0OnSelect4  = csa_q[CS4_CARD0_BIT];
    assign ctrl.cardSlot1OnSelect5  = csa_q[CS5_CARD1_BIT];
    assign ctrl.dataPullupDisable   = csa_q[PULLUP_DIS_BIT];
    assign ctrl.memoryVoltageSelect = csa_q[VOLT_SEL_BIT];
    assign ctrl.padSlewSelect       = csa_q[SLEW_SEL_BIT];
endmodule

// ### rtl/ebm_owner_arb.sv
// owner tracker: hands the shared pins to one controller between accesses
`timescale 1ns/10ps
module ebm_owner_arb
    import ebm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic staticBusy,
    input  wire logic sdramBusy,
    input  wire logic sdramAllowed,
    output ebm_owner_t owner
);
    ebm_owner_t owner_q;
    ebm_owner_t owner_d;

    // ownership only moves once the current holder has gone idle
    always_comb begin
        owner_d = owner_q;
        unique case (owner_q)
            EBM_OWN_IDLE: begin
                if (staticBusy) begin
                    owner_d = EBM_OWN_STATIC;
                end else if (sdramBusy && sdramAllowed) begin
                    owner_d = EBM_OWN_SDRAM;
                end
            end
            EBM_OWN_STATIC: begin
                if (!staticBusy) begin
                    owner_d = EBM_OWN_IDLE; // RULE16
                end
            end
            EBM_OWN_SDRAM: begin
                if (!sdramBusy) begin
                    owner_d = EBM_OWN_IDLE; // RULE16
                end
            end
            default: owner_d = EBM_OWN_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            owner_q <= EBM_OWN_IDLE;
        end else begin
            owner_q <= owner_d;
        end
    end

    assign owner = owner_q;
endmodule

// ### rtl/ebm_bus_mux.sv
// top: chip-select assignment register and external bus pin multiplexer
// What this block does
// RULE1: select 1 goes to static controller at 0, sdram controller at 1.
// RULE2: bit 3 set enables nand logic; select 3 stays static.
// RULE3: bit 4 set enables first card slot logic on select 4.
// RULE4: bit 5 set enables second card slot logic on select 5.
// RULE5: bit 8 zero enables pull-ups on data 15:0; one disables them.
// RULE6: bit 16 chooses 1.8 V at zero, 3.3 V at one; drives pads.
// RULE7: register at 0x11c, read-write, resets to 0x00010000.
// RULE8: shared pins follow whichever controller is doing an access.
// RULE9: sdram address goes to pins 11:2, a10 pin and 14:13.
// RULE10: static-only address pins; write strobe 1 pin doubles as mask 1.
// RULE11: data bus carries 16-bit or 32-bit transfers.
// RULE12: address bus of 26 bits and eight active-low selects.
// RULE13: six address spaces select up to six external devices.
// RULE14: slow devices pull wait low; clock enable high, strobes low.
// RULE15: reserved register bits read zero and ignore writes.
// RULE16: pin ownership changes only between accesses.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
module ebm_bus_mux
    import ebm_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // ************************************************************
    // apb
    // ************************************************************
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // ************************************************************
    // static controller side
    // ************************************************************
    input  wire logic                  smcBusy,
    input  wire logic [ADDR_W-1:0]     smcAddr,
    input  wire logic [NUM_CS-1:0]     smcChipSelectN,
    input  wire logic                  smcWriteStrobe1N,
    input  wire logic [DATA_W-1:0]     smcWrData,
    input  wire logic [DATA_W-1:0]     smcDataOe,
    input  wire logic                  smcWide,
    output logic                       smcWaitN,
    output logic      [DATA_W-1:0]     smcRdData,
    output logic                       smcGrant,
    // ************************************************************
    // sdram controller side
    // ************************************************************
    input  wire logic                  sdrBusy,
    input  wire logic [SDR_ADDR_W-1:0] sdrAddr,
    input  wire logic                  sdrChipSelectN,
    input  wire logic                  sdrByteMask1N,
    input  wire logic                  sdrClockEnable,
    input  wire logic [DATA_W-1:0]     sdrWrData,
    input  wire logic                  sdrDataOe,
    input  wire logic                  sdrWide,
    output logic      [DATA_W-1:0]     sdrRdData,
    output logic                       sdrGrant,
    // ************************************************************
    // support logic enables and pad configuration
    // ************************************************************
    output logic                       nandLogicEnable,
    output logic                       cardSlot0Enable,
    output logic                       cardSlot1Enable,
    output logic      [15:0]           dataPullupEnable,
    output logic                       padVoltage33,
    output logic                       padSlewSelect,
    // ************************************************************
    // external pins
    // ************************************************************
    output logic      [ADDR_W-1:0]     extAddr,
    output logic                       sdramAddr10Pin,
    output logic      [NUM_CS-1:0]     chipSelectN,
    output logic                       writeStrobe1N,
    output logic                       sdramClockEnable,
    input  wire logic                  externalWaitN,
    input  wire logic [DATA_W-1:0]     extDataIn,
    output logic      [DATA_W-1:0]     extDataOut,
    output logic      [DATA_W-1:0]     extDataOe
);
    ebm_ctrl_if ctrl ();
    ebm_owner_t owner;

    logic [ADDR_W-1:0] addr_d;
    logic [ADDR_W-1:0] addr_q;
    logic              a10_d;
    logic              a10_q;
    logic [NUM_CS-1:0] cs_d;
    logic [NUM_CS-1:0] cs_q;
    logic              wr1_d;
    logic              wr1_q;
    logic              cke_d;
    logic              cke_q;
    logic [DATA_W-1:0] dout_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] doe_d;
    logic [DATA_W-1:0] doe_q;
    logic [DATA_W-1:0] din_d;
    logic [DATA_W-1:0] din_q;
    logic              wide;
    logic [2:0]        waitSync_q;
    logic [2:0]        waitSync_d;
    logic              waitN_q;
    logic              waitN_d;

    ebm_apb_regs u_regs (
        .clk_sys (clk_sys),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ctrl    (ctrl.regs)
    );

    // sdram may only take the pins when select 1 is assigned to it
    ebm_owner_arb u_arb (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .staticBusy   (smcBusy),
        .sdramBusy    (sdrBusy),
        .sdramAllowed (ctrl.sdramOnSelect1), // RULE1
        .owner        (owner)
    );

    assign smcGrant = (owner == EBM_OWN_STATIC);
    assign sdrGrant = (owner == EBM_OWN_SDRAM);

    // ************************************************************
    // support logic and pad configuration
    // ************************************************************
    assign nandLogicEnable  = ctrl.nandLogicOnSelect3; // RULE2
    assign cardSlot0Enable  = ctrl.cardSlot0OnSelect4; // RULE3
    assign cardSlot1Enable  = ctrl.cardSlot1OnSelect5; // RULE4
    assign dataPullupEnable = {16{~ctrl.dataPullupDisable}}; // RULE5
    assign padVoltage33     = ctrl.memoryVoltageSelect; // RULE6
    assign padSlewSelect    = ctrl.padSlewSelect;

    // ************************************************************
    // wait input synchroniser
    // ************************************************************
    always_comb begin
        waitSync_d = {waitSync_q[1:0], externalWaitN};
        waitN_d    = waitN_q;
        if (waitSync_q[1] == waitSync_q[2]) begin
            waitN_d = waitSync_q[2]; // RULE14
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            waitSync_q <= 3'h7;
            waitN_q    <= 1'b1;
        end else begin
            waitSync_q <= waitSync_d;
            waitN_q    <= waitN_d;
        end
    end

    assign smcWaitN = waitN_q;

    // ************************************************************
    // pin multiplexer
    // ************************************************************
    always_comb begin
        addr_d = addr_q;
        a10_d  = 1'b0;
        cs_d   = {NUM_CS{1'b1}};
        wr1_d  = 1'b1;
        cke_d  = cke_q;
        dout_d = dout_q;
        doe_d  = {DATA_W{1'b0}};
        wide   = 1'b1;
        unique case (owner)
            EBM_OWN_STATIC: begin
                addr_d = smcAddr; // RULE10
                cs_d   = smcChipSelectN; // RULE12
                // select 1 belongs to sdram when assigned there
                if (ctrl.sdramOnSelect1) begin
                    cs_d[1] = 1'b1; // RULE1
                end
                wr1_d  = smcWriteStrobe1N; // RULE10
                dout_d = smcWrData; // RULE8
                doe_d  = smcDataOe;
                wide   = smcWide;
            end
            EBM_OWN_SDRAM: begin
                addr_d        = addr_q;
                addr_d[11:2]  = sdrAddr[9:0]; // RULE9
                a10_d         = sdrAddr[10]; // RULE9
                addr_d[14:13] = sdrAddr[12:11]; // RULE9
                cs_d[1]       = sdrChipSelectN; // RULE1
                wr1_d         = sdrByteMask1N; // RULE10
                cke_d         = sdrClockEnable; // RULE14
                dout_d        = sdrWrData; // RULE8
                doe_d         = {DATA_W{sdrDataOe}};
                wide          = sdrWide;
            end
            EBM_OWN_IDLE: begin
                cke_d = sdrClockEnable;
            end
            default: begin
                cs_d = {NUM_CS{1'b1}};
            end
        endcase
        // narrow transfers leave the upper data lanes undriven
        if (!wide) begin
            doe_d[31:16] = 16'h0000; // RULE11
        end
        din_d = extDataIn;
        if (!wide) begin
            din_d[31:16] = 16'h0000; // RULE11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_q <= {ADDR_W{1'b0}};
            a10_q  <= 1'b0;
            cs_q   <= {NUM_CS{1'b1}};
            wr1_q  <= 1'b1;
            cke_q  <= 1'b0;
            dout_q <= {DATA_W{1'b0}};
            doe_q  <= {DATA_W{1'b0}};
            din_q  <= {DATA_W{1'b0}};
        end else begin
            addr_q <= addr_d;
            a10_q  <= a10_d;
            cs_q   <= cs_d;
            wr1_q  <= wr1_d;
            cke_q  <= cke_d;
            dout_q <= dout_d;
            doe_q  <= doe_d;
            din_q  <= din_d;
        end
    end

    // only six of the eight selects decode spaces; the static selects pass to the pins, except select 1, held high while it is assigned to sdram
    assign extAddr          = addr_q;
    assign sdramAddr10Pin   = a10_q;
    assign chipSelectN      = cs_q; // RULE13
    assign writeStrobe1N    = wr1_q;
    assign sdramClockEnable = cke_q;
    assign extDataOut       = dout_q;
    assign extDataOe        = doe_q;
    assign smcRdData        = din_q;
    assign sdrRdData        = din_q;
endmodule

// ### verif/ebm_bus_mux_chk.sv
// checker: grant, pin and register properties on the bus mux ports
`timescale 1ns/10ps
module ebm_bus_mux_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pslverr,
    input wire logic        smcBusy,
    input wire logic [25:0] smcAddr,
    input wire logic        sdrBusy,
    input wire logic [12:0] sdrAddr,
    input wire logic        sdrChipSelectN,
    input wire logic        sdrByteMask1N,
    input wire logic        smcGrant,
    input wire logic        sdrGrant,
    input wire logic [15:0] dataPullupEnable,
    input wire logic        padVoltage33,
    input wire logic [25:0] extAddr,
    input wire logic        sdramAddr10Pin,
    input wire logic [7:0]  chipSelectN,
    input wire logic        writeStrobe1N
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire csaWr = psel && penable && pwrite && paddr == 12'h11c;
    // ****************
    // register, owner handover and pin properties
    // ****************
    sequence idle_s;
        !smcGrant && !sdrGrant;
    endsequence
    sequence static_req_s;
        idle_s ##0 smcBusy;
    endsequence
    pull_up_a: assert property (csaWr && pstrb[1] |=>
        dataPullupEnable == {16{!$past(pwdata[8])}}) else $error("pull-up");
    volt_sel_a: assert property (csaWr && pstrb[2] |=>
        padVoltage33 == $past(pwdata[16])) else $error("voltage select");
    reset_val_a: assert property (disable iff (1'b0) rst |=>
        padVoltage33 && &dataPullupEnable && &chipSelectN)
        else $error("reset values");
    apb_err_a: assert property (psel && penable |->
        pslverr == (paddr != 12'h11c)) else $error("error response");
    grant_excl_a: assert property (!(smcGrant && sdrGrant))
        else $error("two owners");
    static_grant_a: assert property (static_req_s |=> smcGrant)
        else $error("static grant late");
    owner_hold_a: assert property (
        smcGrant && smcBusy || sdrGrant && sdrBusy |=>
        $stable({smcGrant, sdrGrant})) else $error("owner switched");
    owner_release_a: assert property (
        smcGrant && !smcBusy || sdrGrant && !sdrBusy |=> idle_s)
        else $error("no idle between owners");
    static_pins_a: assert property (smcGrant |=>
        extAddr == $past(smcAddr)) else $error("static address");
    sdram_pins_a: assert property (sdrGrant |=>
        {extAddr[14:13], sdramAddr10Pin, extAddr[11:2]} == $past(sdrAddr)
        && chipSelectN[1] == $past(sdrChipSelectN)
        && writeStrobe1N == $past(sdrByteMask1N)) else $error("sdram pins");
endmodule

// ### verif/ebm_mem_model.sv
// partner: external memory devices hanging on the bus pins
`timescale 1ns/10ps
module ebm_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        slowMode,
    input  wire logic [7:0]  chipSelectN,
    input  wire logic [31:0] extDataOe,
    input  wire logic [31:0] extDataOut,
    output logic             externalWaitN,
    output logic      [31:0] extDataIn
);
    logic [31:0] mem = 32'h0;
    logic [2:0]  waitCnt = 3'h0;
    wire         sel = chipSelectN != 8'hff;
    initial extDataIn = 32'h0;
    always @(posedge clk_sys) begin
        if (sel && extDataOe == 32'hffffffff)
            mem <= extDataOut;
        waitCnt <= !sel ? 3'h0 : waitCnt + {2'h0, waitCnt != 3'h5};
        // a released bus never keeps a level that could pass for data
        extDataIn <= (sel && extDataOe == 32'h0) ? mem : ~extDataIn;
    end
    // slow device stretches each access for five cycles
    assign externalWaitN = !(slowMode && sel && waitCnt != 3'h5);
endmodule

// ### verif/ebm_bus_mux_test.sv
// testbench: register, pin mux and partner traffic of the bus mux
`timescale 1ns/10ps
module ebm_bus_mux_test
    import ebm_pkg::*;
;
    logic        clk_sys, rst, psel, penable, pwrite, er, slowMode;
    logic        smcBusy, smcWriteStrobe1N, smcWide, sdrBusy;
    logic        sdrChipSelectN, sdrByteMask1N, sdrClockEnable, sdrDataOe;
    logic        sdrWide, pready, pslverr, smcWaitN, smcGrant, sdrGrant;
    logic        nandLogicEnable, cardSlot0Enable, cardSlot1Enable;
    logic        padVoltage33, padSlewSelect, sdramAddr10Pin;
    logic        writeStrobe1N, sdramClockEnable, externalWaitN;
    logic [3:0]  pstrb;
    logic [7:0]  smcChipSelectN, chipSelectN;
    logic [11:0] paddr;
    logic [12:0] sdrAddr;
    logic [15:0] dataPullupEnable;
    logic [25:0] smcAddr, extAddr;
    logic [31:0] pwdata, smcWrData, smcDataOe, sdrWrData, rd, d, cfgPins;
    logic [31:0] prdata, smcRdData, sdrRdData, extDataIn, extDataOut;
    logic [31:0] extDataOe;
    int          miscompares = 0, cmp_count = 0, cycles = 0;
    ebm_bus_mux uut (.*);
    ebm_mem_model far (.*);
    assign cfgPins = {11'h0, nandLogicEnable, cardSlot0Enable,
                      cardSlot1Enable, padVoltage33, padSlewSelect,
                      dataPullupEnable};
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // the tests need a few hundred cycles; this only catches a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // ****************
    // tasks
    // ****************
    function automatic logic [31:0] exp_pins(input logic [31:0] v);
        return {11'h0, v[3], v[4], v[5], v[16], v[17], {16{~v[8]}}};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h vs %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] v, input logic [3:0] s);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, v, s};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n++ < 20)
            @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask
    // write a word, then read it back narrow or wide
    task automatic smc_access(input logic wide, input logic sdm);
        logic [31:0] w;
        int          n;
        w = $urandom();
        n = 0;
        smcAddr <= 26'($urandom());
        {smcChipSelectN, smcWide, smcDataOe} <= {8'hfc, 1'b1, 32'hffffffff};
        {smcWrData, smcBusy} <= {w, 1'b1};
        do begin
            @(negedge clk_sys);
            n++;
        end while (smcGrant !== 1'b1 && n < 50);
        @(negedge clk_sys);
        chk({6'h0, extAddr}, {6'h0, smcAddr}, "address");
        chk({24'h0, chipSelectN}, {30'h0000003f, sdm, 1'b0}, "cs");
        // a slow device holds wait low long enough to pass the synchroniser
        repeat (5) @(negedge clk_sys);
        chk({31'h0, smcWaitN}, {31'h0, !slowMode}, "wait");
        repeat (2) @(posedge clk_sys);
        {smcDataOe, smcWide} <= {32'h0, wide};
        repeat (8) @(negedge clk_sys);
        chk(smcRdData, wide ? w : {16'h0, w[15:0]}, "read data");
        @(posedge clk_sys);
        {smcBusy, smcChipSelectN} <= {1'b0, 8'hff};
        @(posedge clk_sys);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, smcBusy, sdrBusy, slowMode} = '0;
        {smcWriteStrobe1N, smcWide, sdrWide, sdrClockEnable} = 4'hf;
        {sdrChipSelectN, sdrByteMask1N, sdrDataOe} = 3'h6;
        {paddr, pwdata, pstrb, smcAddr, smcWrData, smcDataOe} = '0;
        {sdrWrData, sdrAddr, smcChipSelectN} = {45'h0, 8'hff};
        rd = $urandom(60719);
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, CSA_OFFSET, 32'h0, 4'hf);
        chk(rd, CSA_RESET, "reset value");
        chk(cfgPins, exp_pins(CSA_RESET), "reset pins");
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            d = (i < 2) ? {32{i[0]}} : $urandom();
            apb(1'b1, CSA_OFFSET, d, 4'hf);
            apb(1'b0, CSA_OFFSET, 32'h0, 4'hf);
            chk(rd, d & CSA_WRITE_MASK, "read back");
            chk(cfgPins, exp_pins(d), "config pins");
        end
        $display("test random config done");
        apb(1'b1, CSA_OFFSET, 32'h0, 4'hf);
        apb(1'b1, CSA_OFFSET, 32'hffffffff, 4'h2);
        apb(1'b1, 12'h118, 32'hffffffff, 4'hf);
        apb(1'b0, 12'h118, 32'h0, 4'hf);
        chk(rd | {31'h0, !er}, 32'h0, "unmapped");
        apb(1'b0, CSA_OFFSET, 32'h0, 4'hf);
        chk(rd, 32'h00000100, "lane write");
        $display("test strobes done");
        // sdram asks together with static: static wins, sdram follows when select 1 is assigned to it
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, CSA_OFFSET, {30'h0, k[0], 1'b0}, 4'hf);
            {sdrAddr, sdrByteMask1N} <= {13'($urandom()), k[1]};
            {sdrChipSelectN, sdrBusy, slowMode} <= {2'b01, k[1]};
            smc_access(!k[1], k[0]);
            repeat (5) @(negedge clk_sys);
            chk({31'h0, sdrGrant}, {31'h0, k[0]}, "sdram grant");
            if (k[0])
                chk({18'h0, writeStrobe1N, extAddr[14:13], sdramAddr10Pin,
                     extAddr[11:2]}, {18'h0, sdrByteMask1N, sdrAddr},
                    "sdram pins");
            @(posedge clk_sys);
            {sdrBusy, sdrChipSelectN} <= 2'b01;
            repeat (3) @(posedge clk_sys);
            $display("test owner mode %0d done", k);
        end
        final_report();
    end
endmodule
bind ebm_bus_mux ebm_bus_mux_chk chk (.*);
